// *** rtl/shift_reg4_consts.svh ***
// Summary of operation
// R1 - Mode select alone picks the clocked operation
// R2 - Both select bits low: stages hold
// R3 - Both select bits high: parallel load all stages
// R4 - Low bit only: shift toward higher stages
// R5 - High bit only: shift toward lower stages
// R6 - Serial inputs at first and last stage
// R7 - Inputs other than clear act only on shift clock rise
// R8 - Clear low forces stages low at once
// R9 - Driver keeps inputs stable before clock rise
`ifndef SHIFT_REG4_CONSTS_SVH
`define SHIFT_REG4_CONSTS_SVH

// Geometry
`define STAGE_COUNT 4
`define STAGE_RESET 4'h0

// Positions inside the synchronised input vector
`define IN_PAR_LSB 0
`define IN_PAR_MSB 3
`define IN_SHR_BIT 4
`define IN_SHL_BIT 5
`define IN_MODE_LO_BIT 6
`define IN_MODE_HI_BIT 7
`define IN_CLK_BIT 8
`define IN_CLR_BIT 9
`define IN_WIDTH 10
`define IN_RESET 10'h000

// Mode select encodings {high bit, low bit}
`define MODE_CODE_HOLD 2'h0
`define MODE_CODE_SHR 2'h1
`define MODE_CODE_SHL 2'h2
`define MODE_CODE_LOAD 2'h3

`endif

// *** rtl/shift_reg4_pkg.sv ***
package shift_reg4_pkg;

  // Clocked operation chosen by the mode select pins
  typedef enum logic [1:0] {
    MODE_HOLD,
    MODE_SHIFT_RIGHT,
    MODE_SHIFT_LEFT,
    MODE_LOAD
  } shift_mode_e;

  typedef logic [3:0] stage_t;

endpackage : shift_reg4_pkg

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "shift_reg4_consts.svh"

module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Pins in, synchronised copy out
  input wire logic [`IN_WIDTH-1:0] pins_i,
  output logic [`IN_WIDTH-1:0] synced_o
);

  logic [`IN_WIDTH-1:0] first_stage;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      first_stage <= `IN_RESET;
    end else begin
      first_stage <= pins_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      synced_o <= `IN_RESET;
    end else begin
      synced_o <= first_stage;
    end
  end

endmodule : pin_sync
`default_nettype wire

// *** rtl/bidir_universal_shift_reg4.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "shift_reg4_consts.svh"

module bidir_universal_shift_reg4
  import shift_reg4_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Asynchronous clear pin, active low
  input wire logic master_clear_n_i,
  // Shift clock pin, acts on its rising edge
  input wire logic shift_clock_i,
  // Mode select pins
  input wire logic mode_select_low_bit_i,
  input wire logic mode_select_high_bit_i,
  // Serial data pins
  input wire logic right_shift_serial_in_i,
  input wire logic left_shift_serial_in_i,
  // Parallel data pins
  input wire logic [`STAGE_COUNT-1:0] parallel_load_in_i,
  // Stage outputs
  output logic [`STAGE_COUNT-1:0] stage_out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding used by the stage logic and by the checks

  function automatic shift_mode_e decode_mode(input logic [1:0] code);
    shift_mode_e m;
    m = MODE_HOLD;
    case (code)
      `MODE_CODE_HOLD: m = MODE_HOLD;
      `MODE_CODE_SHR: m = MODE_SHIFT_RIGHT;
      `MODE_CODE_SHL: m = MODE_SHIFT_LEFT;
      `MODE_CODE_LOAD: m = MODE_LOAD;
      default: m = MODE_HOLD;
    endcase
    return m;
  endfunction : decode_mode

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`IN_WIDTH-1:0] pins;
  logic [`IN_WIDTH-1:0] synced;

  assign pins = {master_clear_n_i, shift_clock_i, mode_select_high_bit_i,
                 mode_select_low_bit_i, left_shift_serial_in_i,
                 right_shift_serial_in_i, parallel_load_in_i};

  // Data and shift clock pass equal delay, so data stays aligned to the edge
  pin_sync u_pin_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pins_i(pins),
    .synced_o(synced)
  );

  logic clk_s;
  logic clr_n_s;
  logic shr_s;
  logic shl_s;
  logic [`STAGE_COUNT-1:0] par_s;
  shift_mode_e mode_s;

  assign clk_s = synced[`IN_CLK_BIT];
  assign clr_n_s = synced[`IN_CLR_BIT];
  assign shr_s = synced[`IN_SHR_BIT];
  assign shl_s = synced[`IN_SHL_BIT];
  assign par_s = synced[`IN_PAR_MSB:`IN_PAR_LSB];
  assign mode_s = decode_mode({synced[`IN_MODE_HI_BIT], synced[`IN_MODE_LO_BIT]}); // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // Shift clock rising edge detection

  logic clk_prev;
  logic shift_edge;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  // No edge counts until the clear release has reached the sampled domain
  assign shift_edge = clk_s & ~clk_prev & clr_n_s; // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // Next stage values

  stage_t stage;
  stage_t next_stage;

  genvar gi;
  generate
    for (gi = 0; gi < `STAGE_COUNT; gi++) begin : g_stage
      logic from_lower;
      logic from_upper;
      if (gi == 0) begin : g_first
        assign from_lower = shr_s; // [R6]
      end else begin : g_mid_lo
        assign from_lower = stage[gi-1];
      end
      if (gi == `STAGE_COUNT - 1) begin : g_last
        assign from_upper = shl_s; // [R6]
      end else begin : g_mid_hi
        assign from_upper = stage[gi+1];
      end

      always_comb begin
        case (mode_s)
          MODE_HOLD: next_stage[gi] = stage[gi]; // [R2]
          MODE_SHIFT_RIGHT: next_stage[gi] = from_lower; // [R4]
          MODE_SHIFT_LEFT: next_stage[gi] = from_upper; // [R5]
          MODE_LOAD: next_stage[gi] = par_s[gi]; // [R3]
          default: next_stage[gi] = stage[gi];
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Stage register

  // Clear pin acts without the clock; the reset value is a constant
  always_ff @(posedge clk_i or negedge master_clear_n_i) begin
    if (!master_clear_n_i) begin
      stage <= `STAGE_RESET; // [R8]
    end else if (!reset_n_i) begin
      stage <= `STAGE_RESET;
    end else if (shift_edge) begin
      stage <= next_stage; // [R1] [R7]
    end
  end

  assign stage_out_o = stage;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  mode_only_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    (stage != $past(stage)) |-> ($past(shift_edge) && $past(mode_s) != MODE_HOLD)
  ) else $error("stages changed without an edge in a moving mode");

  hold_keeps_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    (shift_edge && mode_s == MODE_HOLD) |=> (stage_out_o == $past(stage_out_o))
  ) else $error("hold mode altered the stages");

  load_takes_a: assert property ( // [R3]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    (shift_edge && mode_s == MODE_LOAD) |=> (stage_out_o == $past(par_s))
  ) else $error("parallel load did not take the data");

  right_shift_a: assert property ( // [R4]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    (shift_edge && mode_s == MODE_SHIFT_RIGHT)
      |=> (stage_out_o[3:1] == $past(stage_out_o[2:0]))
  ) else $error("shift right moved the wrong bits");

  left_shift_a: assert property ( // [R5]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    (shift_edge && mode_s == MODE_SHIFT_LEFT)
      |=> (stage_out_o[2:0] == $past(stage_out_o[3:1]))
  ) else $error("shift left moved the wrong bits");

  serial_ends_a: assert property ( // [R6]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    shift_edge |=> (($past(mode_s) != MODE_SHIFT_RIGHT || stage_out_o[0] == $past(shr_s))
      && ($past(mode_s) != MODE_SHIFT_LEFT || stage_out_o[3] == $past(shl_s)))
  ) else $error("serial input not taken at the end stage");

  no_edge_a: assert property ( // [R7]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    (!(clk_s && !clk_prev)) |=> $stable(stage_out_o)
  ) else $error("stages changed without a shift clock rise");

  clear_forces_a: assert property ( // [R8]
    @(posedge clk_i) disable iff (!reset_n_i)
    (!master_clear_n_i) |-> (stage_out_o == `STAGE_RESET)
  ) else $error("stages not low while clear is asserted");

  ////////////////////////////////////////////////////////////////////////////
  // Checks from the pins
  // A rise sampled at the pins lands three clocks later, through the synchroniser

  pin_hold_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    ($rose(shift_clock_i) && {mode_select_high_bit_i, mode_select_low_bit_i} == `MODE_CODE_HOLD)
      |-> ##3 $stable(stage_out_o)
  ) else $error("hold rise at the pins altered the stages");

  pin_load_a: assert property ( // [R3]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    ($rose(shift_clock_i) && {mode_select_high_bit_i, mode_select_low_bit_i} == `MODE_CODE_LOAD)
      |-> ##3 (stage_out_o == $past(parallel_load_in_i, 3))
  ) else $error("load rise at the pins did not take the data");

  pin_right_a: assert property ( // [R4]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    ($rose(shift_clock_i) && {mode_select_high_bit_i, mode_select_low_bit_i} == `MODE_CODE_SHR)
      |-> ##3 (stage_out_o == {$past(stage_out_o[2:0]), $past(right_shift_serial_in_i, 3)})
  ) else $error("shift right rise at the pins gave the wrong stages");

  pin_left_a: assert property ( // [R5]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    ($rose(shift_clock_i) && {mode_select_high_bit_i, mode_select_low_bit_i} == `MODE_CODE_SHL)
      |-> ##3 (stage_out_o == {$past(left_shift_serial_in_i, 3), $past(stage_out_o[3:1])})
  ) else $error("shift left rise at the pins gave the wrong stages");

  pin_quiet_a: assert property ( // [R7]
    @(posedge clk_i) disable iff (!reset_n_i || !master_clear_n_i)
    (!$rose(shift_clock_i))
      |-> ##3 $stable(stage_out_o)
  ) else $error("stages changed without a rise at the shift clock pin");

endmodule : bidir_universal_shift_reg4
`default_nettype wire

// *** dv/shift_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module shift_partner (
  // Clock
  input wire logic clk_i,
  // Pins toward the register
  output logic shift_clock_o,
  output logic mode_lo_o,
  output logic mode_hi_o,
  output logic ser_r_o,
  output logic ser_l_o,
  output logic [3:0] par_o
);
  initial begin
    {shift_clock_o, mode_lo_o, mode_hi_o, ser_r_o, ser_l_o, par_o} = 9'h000;
  end
  // One operation; data is inverted once its hold has run out
  task automatic run(input logic [1:0] m, input logic sr, input logic sl, input logic [3:0] d);
    @(negedge clk_i);
    {mode_hi_o, mode_lo_o, ser_r_o, ser_l_o, par_o} = {m, sr, sl, d};
    @(negedge clk_i);
    shift_clock_o = 1'b1;
    repeat (2) @(negedge clk_i);
    shift_clock_o = 1'b0;
    repeat (2) @(negedge clk_i);
    {ser_r_o, ser_l_o, par_o} = ~{sr, sl, d};
  endtask : run
  // Rise in hold, then mode and data move while high and the clock falls
  task automatic no_rise(input logic [1:0] m, input logic [3:0] d);
    @(negedge clk_i);
    {mode_hi_o, mode_lo_o} = 2'h0;
    @(negedge clk_i);
    shift_clock_o = 1'b1;
    repeat (3) @(negedge clk_i);
    {mode_hi_o, mode_lo_o, par_o} = {m, d};
    repeat (2) @(negedge clk_i);
    shift_clock_o = 1'b0;
    repeat (4) @(negedge clk_i);
    {mode_hi_o, mode_lo_o} = 2'h0;
  endtask : no_rise
endmodule : shift_partner
`default_nettype wire

// *** dv/bidir_universal_shift_reg4_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module bidir_universal_shift_reg4_tb;
  import shift_reg4_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clear_n = 1'b1;
  wire logic sclk, mlo, mhi, sr, sl;
  wire logic [3:0] par;
  stage_t q;
  stage_t exp = 4'h0;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  bidir_universal_shift_reg4 i_bidir_universal_shift_reg4 (
    .clk_i(clk), .reset_n_i(reset_n), .master_clear_n_i(clear_n), .shift_clock_i(sclk),
    .mode_select_low_bit_i(mlo), .mode_select_high_bit_i(mhi), .right_shift_serial_in_i(sr),
    .left_shift_serial_in_i(sl), .parallel_load_in_i(par), .stage_out_o(q)
  );
  shift_partner i_shift_partner (
    .clk_i(clk), .shift_clock_o(sclk), .mode_lo_o(mlo), .mode_hi_o(mhi),
    .ser_r_o(sr), .ser_l_o(sl), .par_o(par)
  );

  ////////////////////////////////////////////////////////////
  task automatic check(input string what);
    checked++;
    if (q !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, q, exp);
    end
  endtask : check

  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////
  task automatic t_load;
    i_shift_partner.run(MODE_LOAD, 1'b1, 1'b1, 4'hA);
    exp = 4'hA;
    check("load");
    i_shift_partner.run(MODE_LOAD, 1'b0, 1'b0, 4'h5);
    exp = 4'h5;
    check("load back to back");
    $display("load test done");
  endtask : t_load

  task automatic t_hold;
    i_shift_partner.run(MODE_HOLD, 1'b0, 1'b1, 4'hF);
    check("hold");
    i_shift_partner.no_rise(MODE_LOAD, 4'h3);
    check("pins change without clock rise");
    $display("hold test done");
  endtask : t_hold

  task automatic t_shift;
    i_shift_partner.run(MODE_SHIFT_RIGHT, 1'b1, 1'b0, 4'h0);
    exp = {exp[2:0], 1'b1};
    check("shift right one");
    i_shift_partner.run(MODE_SHIFT_RIGHT, 1'b0, 1'b1, 4'hF);
    exp = {exp[2:0], 1'b0};
    check("shift right zero");
    i_shift_partner.run(MODE_SHIFT_LEFT, 1'b0, 1'b1, 4'h0);
    exp = {1'b1, exp[3:1]};
    check("shift left one");
    i_shift_partner.run(MODE_SHIFT_LEFT, 1'b1, 1'b0, 4'hF);
    exp = {1'b0, exp[3:1]};
    check("shift left zero");
    $display("shift test done");
  endtask : t_shift

  task automatic t_clear;
    @(negedge clk);
    clear_n = 1'b0;
    #1;
    exp = 4'h0;
    check("clear at once");
    i_shift_partner.run(MODE_LOAD, 1'b1, 1'b1, 4'hC);
    check("clock rise under clear");
    @(negedge clk);
    clear_n = 1'b1;
    repeat (3) @(negedge clk);
    $display("clear test done");
  endtask : t_clear

  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check("after reset");
    t_load();
    t_hold();
    t_shift();
    t_clear();
    t_load();
    close_out();
  end
endmodule : bidir_universal_shift_reg4_tb
`default_nettype wire
